// *** rtl/lrm_regs_top.sv ***
`timescale 1ns/100ps
`include "lrm_regs.svh"

// How it works
// - With the override bit set the local transmit-mode bits drive the mode, else the back-channel bits do.
// - Bit 4 of the mode register reads back whether the back-channel mode is current, resetting to 0.
// - Bits 3 and 2 of the mode register read the pin-selected 12-bit and 10-bit modes, resetting to 0.
// - Writable bit 1 selects the 12-bit transmit bus, effective only under override.
// - Writable bit 0 selects the 10-bit transmit bus, effective only under override.
// - Bits 7:1 of the remote id register hold the remote address, reset zero, and zero blocks access.
// - After receive lock the remote id is loaded automatically from the control channel.
// - A set id-lock bit blocks the automatic load and keeps the written id.
// - Transactions to the nonzero remote alias are remapped to the remote id.
// - Transactions to the slave alias are remapped to the downstream id, and a zero id blocks them.
// - Alias forwarding only works while pass-through is enabled.
// - The slave alias sits in its own register at 0x09 and steers matches to the remote slave.
module lrm_regs_top
  import lrm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [`LRM_ADDR_W-1:0] reg_addr,
  input wire lrm_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lrm_byte_t reg_rdata,
  // back channel and pins
  input wire logic [1:0] bc_mode,
  input wire logic bc_mode_current,
  input wire logic pin_mode_wide,
  input wire logic pin_mode_mid,
  input wire logic rx_lock,
  input wire lrm_i2c_addr_t bc_remote_id,
  input wire logic bc_remote_id_valid,
  // effective transmit mode
  output logic tx_mode_wide,
  output logic tx_mode_mid,
  // local i2c transactions in
  input wire logic i2c_addr_valid,
  input wire lrm_i2c_addr_t i2c_addr,
  input wire logic i2c_rw,
  input wire logic i2c_data_valid,
  input wire lrm_byte_t i2c_data,
  // forwarded transactions out
  output logic fwd_valid,
  output lrm_i2c_addr_t fwd_addr,
  output logic fwd_rw,
  output lrm_route_e fwd_route,
  output logic fwd_drop,
  output logic fwd_data_valid,
  output lrm_byte_t fwd_data
);

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic mode_ovr, next_mode_ovr, pass_en, next_pass_en, lock_seen, next_lock_seen;
  logic [1:0] mode_local, next_mode_local;
  lrm_byte_t rid, next_rid, rdata_next;
  lrm_i2c_addr_t ralias, next_ralias, did, next_did, dalias, next_dalias;
  logic mode_cur, next_mode_cur, pin_wide, next_pin_wide, pin_mid, next_pin_mid;

  always_comb
  begin
    next_mode_ovr = mode_ovr;
    next_mode_local = mode_local;
    next_rid = rid;
    next_ralias = ralias;
    next_did = did;
    next_dalias = dalias;
    next_pass_en = pass_en;
    next_mode_cur = bc_mode_current;
    next_pin_wide = pin_mode_wide;
    next_pin_mid = pin_mode_mid;
    next_lock_seen = rx_lock;
    // auto-load on lock rise or on a fresh id while locked, unless frozen
    if (!rid[`LRM_ID_LOCK_BIT] && rx_lock && (!lock_seen || bc_remote_id_valid))
    begin
      next_rid = {bc_remote_id, rid[`LRM_ID_LOCK_BIT]};
    end
    // software write wins over a same-cycle auto-load
    if (reg_wr)
    begin
      if (reg_addr == `LRM_OFS_MODE)
      begin
        next_mode_ovr = reg_wdata[`LRM_MODE_OVR_BIT];
        next_mode_local = {reg_wdata[`LRM_MODE_WIDE_BIT], reg_wdata[`LRM_MODE_MID_BIT]};
      end
      else if (reg_addr == `LRM_OFS_RID)
        next_rid = reg_wdata;
      else if (reg_addr == `LRM_OFS_RALIAS)
        next_ralias = reg_wdata[`LRM_ID_MSB:`LRM_ID_LSB];
      else if (reg_addr == `LRM_OFS_DID)
        next_did = reg_wdata[`LRM_ID_MSB:`LRM_ID_LSB];
      else if (reg_addr == `LRM_OFS_DALIAS)
        next_dalias = reg_wdata[`LRM_ID_MSB:`LRM_ID_LSB];
      else if (reg_addr == `LRM_OFS_FWD_CTRL)
        next_pass_en = reg_wdata[`LRM_FWD_PASS_BIT];
    end
  end

  // read mux; reserved and unmapped bits read zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == `LRM_OFS_MODE)
      begin
        rdata_next[`LRM_MODE_OVR_BIT] = mode_ovr;
        rdata_next[`LRM_MODE_CUR_BIT] = mode_cur;
        rdata_next[`LRM_MODE_PIN12_BIT] = pin_wide;
        rdata_next[`LRM_MODE_PIN10_BIT] = pin_mid;
        rdata_next[`LRM_MODE_WIDE_BIT] = mode_local[1];
        rdata_next[`LRM_MODE_MID_BIT] = mode_local[0];
      end
      else if (reg_addr == `LRM_OFS_RID)
        rdata_next = rid;
      else if (reg_addr == `LRM_OFS_RALIAS)
        rdata_next = {ralias, 1'b0};
      else if (reg_addr == `LRM_OFS_DID)
        rdata_next = {did, 1'b0};
      else if (reg_addr == `LRM_OFS_DALIAS)
        rdata_next = {dalias, 1'b0};
      else if (reg_addr == `LRM_OFS_FWD_CTRL)
        rdata_next[`LRM_FWD_PASS_BIT] = pass_en;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mode_ovr <= 1'(`LRM_RST_MODE >> `LRM_MODE_OVR_BIT);
      mode_local <= 2'(`LRM_RST_MODE);
      rid <= `LRM_RST_ID;
      ralias <= `LRM_ADDR_ZERO;
      did <= `LRM_ADDR_ZERO;
      dalias <= `LRM_ADDR_ZERO;
      pass_en <= 1'(`LRM_RST_FWD_CTRL >> `LRM_FWD_PASS_BIT);
      mode_cur <= 1'b0;
      pin_wide <= 1'b0;
      pin_mid <= 1'b0;
      lock_seen <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      mode_ovr <= next_mode_ovr;
      mode_local <= next_mode_local;
      rid <= next_rid;
      ralias <= next_ralias;
      did <= next_did;
      dalias <= next_dalias;
      pass_en <= next_pass_en;
      mode_cur <= next_mode_cur;
      pin_wide <= next_pin_wide;
      pin_mid <= next_pin_mid;
      lock_seen <= next_lock_seen;
      reg_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective transmit mode

  logic next_tx_wide, next_tx_mid;
  // both bits set by software is not guarded; both are passed as written
  always_comb
  begin
    next_tx_wide = mode_ovr ? mode_local[1] : bc_mode[1];
    next_tx_mid = mode_ovr ? mode_local[0] : bc_mode[0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_mode_wide <= 1'b0;
      tx_mode_mid <= 1'b0;
    end
    else
    begin
      tx_mode_wide <= next_tx_wide;
      tx_mode_mid <= next_tx_mid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alias decode and address remap

  logic hit_remote, hit_slave;
  logic next_fwd_valid, next_fwd_rw, next_fwd_drop, next_fwd_data_valid;
  lrm_i2c_addr_t next_fwd_addr;
  lrm_route_e next_fwd_route;
  lrm_byte_t next_fwd_data;

  lrm_alias_match u_match_remote (
    .enable(pass_en),
    .alias_addr(ralias),
    .target_addr(rid[`LRM_ID_MSB:`LRM_ID_LSB]),
    .addr(i2c_addr),
    .hit(hit_remote)
  );

  lrm_alias_match u_match_slave (
    .enable(pass_en),
    .alias_addr(dalias),
    .target_addr(did),
    .addr(i2c_addr),
    .hit(hit_slave)
  );

  // remote deserializer wins if both aliases are programmed alike
  always_comb
  begin
    next_fwd_valid = 1'b0;
    next_fwd_drop = 1'b0;
    next_fwd_addr = fwd_addr;
    next_fwd_rw = fwd_rw;
    next_fwd_route = fwd_route;
    next_fwd_data_valid = i2c_data_valid;
    next_fwd_data = i2c_data_valid ? i2c_data : fwd_data;
    if (i2c_addr_valid)
    begin
      next_fwd_rw = i2c_rw;
      if (hit_remote)
      begin
        next_fwd_valid = 1'b1;
        next_fwd_addr = rid[`LRM_ID_MSB:`LRM_ID_LSB];
        next_fwd_route = route_remote;
      end
      else if (hit_slave)
      begin
        next_fwd_valid = 1'b1;
        next_fwd_addr = did;
        next_fwd_route = route_slave;
      end
      else
      begin
        next_fwd_drop = 1'b1;
        next_fwd_route = route_none;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fwd_valid <= 1'b0;
      fwd_addr <= `LRM_ADDR_ZERO;
      fwd_rw <= 1'b0;
      fwd_route <= route_none;
      fwd_drop <= 1'b0;
      fwd_data_valid <= 1'b0;
      fwd_data <= 8'h00;
    end
    else
    begin
      fwd_valid <= next_fwd_valid;
      fwd_addr <= next_fwd_addr;
      fwd_rw <= next_fwd_rw;
      fwd_route <= next_fwd_route;
      fwd_drop <= next_fwd_drop;
      fwd_data_valid <= next_fwd_data_valid;
      fwd_data <= next_fwd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_remote_req;
    i2c_addr_valid && pass_en && ralias != 7'h00 && rid[7:1] != 7'h00 && i2c_addr == ralias;
  endsequence
  sequence s_fwd_remote;
    fwd_valid && fwd_route == route_remote;
  endsequence

  property p_override_mode;
    mode_ovr |=> tx_mode_wide == $past(mode_local[1]) && tx_mode_mid == $past(mode_local[0]);
  endproperty
  a_override_mode: assert property (p_override_mode) else $error("override mode not applied");
  property p_bc_mode;
    !mode_ovr |=> {tx_mode_wide, tx_mode_mid} == $past(bc_mode);
  endproperty
  a_bc_mode: assert property (p_bc_mode) else $error("back-channel mode not applied");
  property p_mode_current_read;
    reg_rd && reg_addr == 8'h05 |=> reg_rdata[4] == $past(mode_cur) && reg_rdata[3] == $past(pin_wide);
  endproperty
  a_mode_current_read: assert property (p_mode_current_read) else $error("mode status readback wrong");
  property p_pin_mid_track;
    pin_mode_mid ##1 pin_mode_mid |-> pin_mid;
  endproperty
  a_pin_mid_track: assert property (p_pin_mid_track) else $error("pin mode status stale");
  property p_local_bits_write;
    reg_wr && reg_addr == 8'h05 |=> mode_local == $past(reg_wdata[1:0]) && mode_ovr == $past(reg_wdata[5]);
  endproperty
  a_local_bits_write: assert property (p_local_bits_write) else $error("mode write lost");
  property p_autoload;
    rx_lock && !lock_seen && !rid[0] && !reg_wr |=> rid[7:1] == $past(bc_remote_id);
  endproperty
  a_autoload: assert property (p_autoload) else $error("remote id not loaded at lock");
  property p_id_frozen;
    rid[0] && !reg_wr |=> $stable(rid);
  endproperty
  a_id_frozen: assert property (p_id_frozen) else $error("locked id changed");
  property p_remote_remap;
    s_remote_req |=> s_fwd_remote ##0 fwd_addr == $past(rid[7:1]) ##0 fwd_rw == $past(i2c_rw);
  endproperty
  a_remote_remap: assert property (p_remote_remap) else $error("remote alias not remapped");
  property p_slave_remap;
    fwd_valid && fwd_route == route_slave |-> fwd_addr != 7'h00 && $past(i2c_addr) == $past(dalias);
  endproperty
  a_slave_remap: assert property (p_slave_remap) else $error("slave remap wrong");
  property p_no_pass;
    i2c_addr_valid && !pass_en |=> fwd_drop && !fwd_valid;
  endproperty
  a_no_pass: assert property (p_no_pass) else $error("forwarded without pass-through");
  property p_data_through;
    i2c_data_valid |=> fwd_data_valid && fwd_data == $past(i2c_data);
  endproperty
  a_data_through: assert property (p_data_through) else $error("data byte altered");

endmodule

// *** rtl/lrm_regs.svh ***
`ifndef LRM_REGS_SVH
`define LRM_REGS_SVH

// register offsets (byte addresses on the plain register port)
`define LRM_ADDR_W 8
`define LRM_OFS_FWD_CTRL 8'h03
`define LRM_OFS_MODE 8'h05
`define LRM_OFS_RID 8'h06
`define LRM_OFS_RALIAS 8'h07
`define LRM_OFS_DID 8'h08
`define LRM_OFS_DALIAS 8'h09

// mode register fields
`define LRM_MODE_OVR_BIT 5
`define LRM_MODE_CUR_BIT 4
`define LRM_MODE_PIN12_BIT 3
`define LRM_MODE_PIN10_BIT 2
`define LRM_MODE_WIDE_BIT 1
`define LRM_MODE_MID_BIT 0

// id and alias fields
`define LRM_ID_MSB 7
`define LRM_ID_LSB 1
`define LRM_ID_LOCK_BIT 0

// forwarding control fields
`define LRM_FWD_PASS_BIT 2

// reset values
`define LRM_RST_MODE 8'h00
`define LRM_RST_ID 8'h00
`define LRM_RST_ALIAS 8'h00
`define LRM_RST_FWD_CTRL 8'h04
`define LRM_ADDR_ZERO 7'h00

`endif

// *** rtl/lrm_pkg.sv ***
package lrm_pkg;
  typedef logic [7:0] lrm_byte_t;
  typedef logic [6:0] lrm_i2c_addr_t;
  typedef enum logic [1:0] {route_none, route_remote, route_slave} lrm_route_e;
endpackage

// *** rtl/lrm_alias_match.sv ***
`timescale 1ns/100ps
`include "lrm_regs.svh"

module lrm_alias_match
  import lrm_pkg::*;
(
  // configuration
  input wire logic enable,
  input wire lrm_i2c_addr_t alias_addr,
  input wire lrm_i2c_addr_t target_addr,
  // transaction address
  input wire lrm_i2c_addr_t addr,
  // result
  output logic hit
);

  // a zero alias or a zero target both close the path
  always_comb
  begin
    hit = enable && (alias_addr != `LRM_ADDR_ZERO) && (target_addr != `LRM_ADDR_ZERO) && (addr == alias_addr);
  end

endmodule

// *** tb/lrm_far_model.sv ***
`timescale 1ns/100ps
module lrm_far_model
  import lrm_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // scenario control
  input wire logic lock_req,
  input wire logic offer,
  input wire lrm_i2c_addr_t offer_id,
  // control channel towards the block
  output logic rx_lock = 1'b0,
  output lrm_i2c_addr_t bc_remote_id = 7'h00,
  output logic bc_remote_id_valid = 1'b0
);
  // the id is only meaningful in the valid cycle; otherwise it toggles so a stale sample shows up
  always @(posedge ref_clk)
  begin
    rx_lock <= lock_req;
    bc_remote_id_valid <= offer;
    bc_remote_id <= offer ? offer_id : ~bc_remote_id;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import lrm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  lrm_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [1:0] bc_mode = 2'h0;
  logic bc_mode_current = 1'b0, pin_mode_wide = 1'b0, pin_mode_mid = 1'b0;
  logic lock_req = 1'b0, offer = 1'b0;
  lrm_i2c_addr_t offer_id = 7'h00, i2c_addr = 7'h00;
  logic i2c_addr_valid = 1'b0, i2c_rw = 1'b0, i2c_data_valid = 1'b0;
  lrm_byte_t i2c_data = 8'h00;
  lrm_byte_t reg_rdata, fwd_data;
  logic tx_mode_wide, tx_mode_mid, rx_lock, bc_remote_id_valid, fwd_valid, fwd_rw, fwd_drop, fwd_data_valid;
  lrm_i2c_addr_t bc_remote_id, fwd_addr, ra, da, id1, id2, id3;
  lrm_route_e fwd_route;
  int errors = 0, tests_run = 0;
  logic [31:0] seed = 32'hde8e;
  logic [10:0] rq[$], fq[$];
  lrm_byte_t dq[$];
  logic [7:0] mtab [4] = '{8'h22, 8'h21, 8'h02, 8'h3c};
  localparam logic [10:0] drop_exp = {1'b1, route_none, 8'h00};

  initial forever #5 ref_clk = ~ref_clk;

  lrm_regs_top lrm_regs_top_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bc_mode(bc_mode), .bc_mode_current(bc_mode_current),
    .pin_mode_wide(pin_mode_wide), .pin_mode_mid(pin_mode_mid), .rx_lock(rx_lock), .bc_remote_id(bc_remote_id),
    .bc_remote_id_valid(bc_remote_id_valid), .tx_mode_wide(tx_mode_wide), .tx_mode_mid(tx_mode_mid),
    .i2c_addr_valid(i2c_addr_valid), .i2c_addr(i2c_addr), .i2c_rw(i2c_rw), .i2c_data_valid(i2c_data_valid),
    .i2c_data(i2c_data), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_rw(fwd_rw), .fwd_route(fwd_route),
    .fwd_drop(fwd_drop), .fwd_data_valid(fwd_data_valid), .fwd_data(fwd_data));
  lrm_far_model lrm_far_model_i (.ref_clk(ref_clk), .lock_req(lock_req), .offer(offer), .offer_id(offer_id),
    .rx_lock(rx_lock), .bc_remote_id(bc_remote_id), .bc_remote_id_valid(bc_remote_id_valid));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input lrm_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input lrm_byte_t e);
    rq.push_back({3'b000, e});
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  // far end offers an id together with lock
  task automatic give(input lrm_i2c_addr_t id);
    @(posedge ref_clk);
    lock_req <= 1'b1;
    offer <= 1'b1;
    offer_id <= id;
    @(posedge ref_clk);
    offer <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // data byte only follows forwarded addresses
  task automatic xfer(input lrm_i2c_addr_t a, input logic [10:0] e);
    logic [31:0] r;
    r = rnd();
    fq.push_back(e);
    @(posedge ref_clk);
    i2c_addr_valid <= 1'b1;
    i2c_addr <= a;
    i2c_rw <= e[0];
    @(posedge ref_clk);
    i2c_addr_valid <= 1'b0;
    i2c_data_valid <= !e[10];
    i2c_data <= r[7:0];
    if (!e[10])
      dq.push_back(r[7:0]);
    @(posedge ref_clk);
    i2c_data_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk({3'b000, reg_rdata}, rq.size() ? rq.pop_front() : 'x);
    if (!reset && {fwd_valid, fwd_drop} !== 2'b00)
      chk({fwd_drop, fwd_route, fwd_drop ? 8'h00 : {fwd_addr, fwd_rw}}, fq.size() ? fq.pop_front() : 'x);
    if (!reset && fwd_data_valid !== 1'b0)
      chk({3'b000, fwd_data}, dq.size() ? {3'b000, dq.pop_front()} : 'x);
  end

  initial
  begin
    repeat (50000) @(posedge ref_clk);
    errors++;
    final_report();
  end

  initial
  begin
    logic [31:0] r;
    logic [2:0] cur_v;
    logic [1:0] tx_e;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h03, 8'h04);
    for (int a = 4; a <= 9; a++)
      rd(8'(a), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      cur_v = r[2:0];
      {bc_mode_current, pin_mode_wide, pin_mode_mid} <= r[2:0];
      repeat (2) @(posedge ref_clk);
      rd(8'h05, {3'b000, cur_v, 2'b00});
    end
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      @(posedge ref_clk);
      bc_mode <= r[1:0];
      tx_e = mtab[i][5] ? mtab[i][1:0] : r[1:0];
      wr(8'h05, mtab[i]);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({9'h000, tx_mode_wide, tx_mode_mid}, {9'h000, tx_e});
    end
    rd(8'h05, {3'b001, cur_v, 2'b00});
    r = rnd();
    id1 = {1'b1, r[5:0]};
    give(id1);
    rd(8'h06, {id1, 1'b0});
    id2 = {1'b1, r[11:6]};
    id3 = {2'b01, id2[4:0]};
    wr(8'h06, {id2, 1'b1});
    give(id3);
    rd(8'h06, {id2, 1'b1});
    wr(8'h06, {id2, 1'b0});
    give(id3);
    rd(8'h06, {id3, 1'b0});
    ra = {3'b001, r[15:12]};
    da = {3'b010, r[19:16]};
    id1 = {1'b1, r[25:20]};
    wr(8'h07, {ra, 1'b1});
    wr(8'h08, {id1, 1'b1});
    wr(8'h09, {da, 1'b1});
    rd(8'h07, {ra, 1'b0});
    rd(8'h08, {id1, 1'b0});
    rd(8'h09, {da, 1'b0});
    xfer(ra, {1'b0, route_remote, id3, r[26]});
    xfer(da, {1'b0, route_slave, id1, r[27]});
    xfer({3'b011, r[3:0]}, drop_exp);
    wr(8'h03, 8'h00);
    xfer(ra, drop_exp);
    wr(8'h03, 8'h04);
    wr(8'h08, 8'h00);
    xfer(da, drop_exp);
    wr(8'h06, 8'h01);
    xfer(ra, drop_exp);
    wr(8'h06, {id3, 1'b1});
    wr(8'h07, 8'h00);
    xfer(ra, drop_exp);
    for (int i = 0; i < 20 && (rq.size() + fq.size() + dq.size()) != 0; i++)
      @(posedge ref_clk);
    if ((rq.size() + fq.size() + dq.size()) != 0)
      errors++;
    final_report();
  end
endmodule
